// ---- design/dbi_pkg.sv ----
// Constants and types for the debounced input block
//
// Contract
// RULE1: 32 inputs form four ports of eight, each with its own filter.
// RULE2: Reading one port returns its eight channel levels as one byte.
// RULE3: Host selects the port to read with an index from zero to three.
// RULE4: Debounce setting bits 2:0 hold the factor for channels 0 to 7.
// RULE5: Debounce setting bits 6:4 hold channels 8 to 15; bits 3, 7 unused.
// RULE6: Debounce window equals programmed factor times 20 ms.
// RULE7: Factor zero bypasses the filter, passing raw levels straight through.
// RULE8: Interrupt setting bit 0 enables edge interrupts for channels 0 to 7.
// RULE9: Interrupt setting bit 1 enables edge interrupts for channels 8 to 15.
// RULE10: Interrupt setting bit 2 picks edge for channels 0-7: 0 rise, 1 fall.
// RULE11: Interrupt setting bit 3 picks edge of channels 8-15: 0 rise, 1 fall.
// RULE12: Interrupt setting bits 7:4 do nothing and are ignored on write.
// RULE13: Interrupt flags: one bit per channel 0-15, set when it interrupted.
// RULE14: A host clear operation resets every interrupt flag to zero; a flag whose edge lands in the clear cycle stays set.
// RULE15: A host disable operation turns off interrupts for all channels.
// RULE16: Card number one to four is read from the on-board jumper.
// RULE17: Edge detector flags enabled lower-16 changes in chosen direction.
// RULE18: With debounce enabled, channels are sampled once every 20 ms.
// RULE19: Level taken only after a full stable window; shorter pulses dropped.
// RULE20: Interrupt request high while any flag is set, low once cleared.
// RULE21: The 20 ms tick comes from a free-running system clock divider.
package dbi_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_PORTS  = 4;
    localparam int PORT_W     = 8;
    localparam int FACTOR_W   = 3;
    localparam int IRQ_CH     = 16;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ      = 25000000;
    localparam longint TICK_MS     = 20;
    localparam int     TICK_CYCLES = int'((CLK_HZ * TICK_MS) / 1000);

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_DATA   = 8'h00;
    localparam logic [7:0] OFS_PORT_SELECT = 8'h04;
    localparam logic [7:0] OFS_DEB_LO      = 8'h08;
    localparam logic [7:0] OFS_DEB_HI      = 8'h0c;
    localparam logic [7:0] OFS_INT_SET     = 8'h10;
    localparam logic [7:0] OFS_INT_FLAGS   = 8'h14;
    localparam logic [7:0] OFS_INT_CLEAR   = 8'h18;
    localparam logic [7:0] OFS_INT_DISABLE = 8'h1c;
    localparam logic [7:0] OFS_CARD_NUM    = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DEB_F0_LSB   = 0;
    localparam int DEB_F1_LSB   = 4;
    localparam int INT_EN0_BIT  = 0;
    localparam int INT_EN1_BIT  = 1;
    localparam int INT_POL0_BIT = 2;
    localparam int INT_POL1_BIT = 3;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0]  DEB_RST      = 8'h00;
    localparam logic [7:0]  DEB_MASK     = 8'h77;
    localparam logic [3:0]  INT_SET_RST  = 4'h0;
    localparam logic [15:0] FLAGS_RST    = 16'h0000;
    localparam logic [1:0]  PSEL_RST     = 2'h0;

    // ------------------------------------------------------------
    // Filter state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PORT_W-1:0]               level;
        logic [PORT_W-1:0]               cand;
        logic [PORT_W-1:0][FACTOR_W-1:0] cnt;
    } dbi_flt_st_t;

endpackage : dbi_pkg

// ---- design/dbi_flt_if.sv ----
// Link between the control block and one port filter
interface dbi_flt_if
    import dbi_pkg::*;
    ();
    logic                ce;
    logic                tick;
    logic [FACTOR_W-1:0] factor;
    logic [PORT_W-1:0]   raw;
    logic [PORT_W-1:0]   level;

    modport ctl (output ce, output tick, output factor, output raw,
                 input level);
    modport flt (input ce, input tick, input factor, input raw,
                 output level);
endinterface : dbi_flt_if

// ---- design/dbi_tick.sv ----
// Free-running divider making the debounce sampling tick
module dbi_tick
    import dbi_pkg::*;
#(
    parameter int PERIOD = TICK_CYCLES
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    output logic      tick
);
    localparam int CW = $clog2(PERIOD + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } dbi_tick_st_t;

    dbi_tick_st_t st_r;
    dbi_tick_st_t st_nxt;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt == CW'(PERIOD - 1)) begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1; // [RULE21]
        end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule : dbi_tick

// ---- design/dbi_filter.sv ----
// Debounce filter for one eight-channel port
module dbi_filter
    import dbi_pkg::*;
(
    input wire logic  hclk,
    input wire logic  hresetn,
    dbi_flt_if.flt    fi
);
    dbi_flt_st_t st_r;
    dbi_flt_st_t st_nxt;

    // ------------------------------------------------------------
    // Per-channel stability count
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (fi.factor == '0) begin
            st_nxt.level = fi.raw; // [RULE7]
            st_nxt.cand  = fi.raw;
            st_nxt.cnt   = '0;
        end else if (fi.tick) begin // [RULE18]
            for (int i = 0; i < PORT_W; i++) begin
                if (fi.raw[i] != st_r.cand[i]) begin
                    st_nxt.cand[i] = fi.raw[i];
                    st_nxt.cnt[i]  = FACTOR_W'(1);
                end else if (st_r.cnt[i] < fi.factor) begin
                    st_nxt.cnt[i] = st_r.cnt[i] + FACTOR_W'(1);
                end
                if (st_nxt.cnt[i] >= fi.factor) begin
                    st_nxt.level[i] = st_nxt.cand[i]; // [RULE6] [RULE19]
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else if (fi.ce) begin
            st_r <= st_nxt;
        end
    end

    assign fi.level = st_r.level;
endmodule : dbi_filter

// ---- design/dbi_top.sv ----
// Debounced digital input block with edge interrupts on AHB-Lite
//
// Our own choices: the register offsets and the AHB-Lite register port.
module dbi_top
    import dbi_pkg::*;
#(
    parameter int TICK_PERIOD = TICK_CYCLES,
    parameter int NPORT       = NUM_PORTS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [31:0] input_channel,
    input  wire logic [1:0]  card_number_jumper,
    output logic             irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                    dph_wr;
        logic [7:0]              dph_addr;
        logic                    dph_ok;
        logic [1:0]              port_select;
        logic [7:0]              deb_lo;
        logic [7:0]              deb_hi;
        logic [3:0]              int_set;
        logic [IRQ_CH-1:0]       flags;
        logic [IRQ_CH-1:0]       prev;
        logic                    prev_ok;
        logic [2:0]              card;
        logic                    strap_done;
        logic [31:0]             rdata;
        logic                    irq;
    } dbi_top_st_t;

    dbi_top_st_t st_r;
    dbi_top_st_t st_nxt;

    logic                          tick;
    logic [NPORT-1:0][PORT_W-1:0]  lvl;

    // ------------------------------------------------------------
    // Tick and port filters
    // ------------------------------------------------------------
    dbi_tick #(
        .PERIOD (TICK_PERIOD)
    ) u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .tick    (tick)
    );

    dbi_flt_if fi [NPORT] ();

    for (genvar g = 0; g < NPORT; g++) begin : g_port
        assign fi[g].ce   = ce;
        assign fi[g].tick = tick;
        assign fi[g].raw  = input_channel[g*PORT_W +: PORT_W]; // [RULE1]
        assign lvl[g]     = fi[g].level;
        if (g == 0) begin : g_f0
            assign fi[g].factor =
                st_r.deb_lo[DEB_F0_LSB +: FACTOR_W]; // [RULE4]
        end else if (g == 1) begin : g_f1
            assign fi[g].factor =
                st_r.deb_lo[DEB_F1_LSB +: FACTOR_W]; // [RULE5]
        end else if (g == 2) begin : g_f2
            assign fi[g].factor = st_r.deb_hi[DEB_F0_LSB +: FACTOR_W];
        end else begin : g_f3
            assign fi[g].factor = st_r.deb_hi[DEB_F1_LSB +: FACTOR_W];
        end
        dbi_filter u_flt (
            .hclk    (hclk),
            .hresetn (hresetn),
            .fi      (fi[g])
        );
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [PORT_W-1:0] edge_evt(
        input logic [PORT_W-1:0] was,
        input logic [PORT_W-1:0] now,
        input logic              fall
    );
        edge_evt = fall ? (was & ~now) : (~was & now);
    endfunction : edge_evt

    function automatic logic [31:0] rd_mux(
        input dbi_top_st_t              s,
        input logic [7:0]               a,
        input logic [NPORT-1:0][PORT_W-1:0] l
    );
        rd_mux = 32'h0000_0000;
        case (a)
            OFS_PORT_DATA:   rd_mux = {24'h00_0000, l[s.port_select]};
            OFS_PORT_SELECT: rd_mux = {30'h0000_0000, s.port_select};
            OFS_DEB_LO:      rd_mux = {24'h00_0000, s.deb_lo};
            OFS_DEB_HI:      rd_mux = {24'h00_0000, s.deb_hi};
            OFS_INT_SET:     rd_mux = {28'h000_0000, s.int_set};
            OFS_INT_FLAGS:   rd_mux = {16'h0000, s.flags};
            OFS_CARD_NUM:    rd_mux = {29'h0000_0000, s.card};
            default:         rd_mux = 32'h0000_0000;
        endcase
    endfunction : rd_mux

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic              aph;
    logic              clr;
    logic [IRQ_CH-1:0] ev;

    always_comb begin
        st_nxt = st_r;
        clr    = 1'b0;
        ev     = '0;
        aph    = hsel && htrans[1] && hready;

        // Jumper caught once after reset release
        if (!st_r.strap_done) begin
            st_nxt.card       = {1'b0, card_number_jumper} + 3'h1; // [RULE16]
            st_nxt.strap_done = 1'b1;
        end

        // Data phase of a write
        if (st_r.dph_ok && st_r.dph_wr) begin
            case (st_r.dph_addr)
                OFS_PORT_SELECT: st_nxt.port_select = hwdata[1:0]; // [RULE3]
                OFS_DEB_LO:      st_nxt.deb_lo =
                    hwdata[7:0] & DEB_MASK; // [RULE5]
                OFS_DEB_HI:      st_nxt.deb_hi = hwdata[7:0] & DEB_MASK;
                OFS_INT_SET:     st_nxt.int_set = hwdata[3:0]; // [RULE12]
                OFS_INT_CLEAR:   clr = 1'b1; // [RULE14]
                OFS_INT_DISABLE: begin
                    st_nxt.int_set[INT_EN0_BIT] = 1'b0; // [RULE15]
                    st_nxt.int_set[INT_EN1_BIT] = 1'b0;
                end
                default: ;
            endcase
        end

        // Edge detection on filtered levels of the lower sixteen
        st_nxt.prev    = {lvl[1], lvl[0]};
        st_nxt.prev_ok = 1'b1;
        if (st_r.prev_ok) begin
            if (st_r.int_set[INT_EN0_BIT]) begin // [RULE8]
                ev[7:0] = edge_evt(st_r.prev[7:0], lvl[0], // [RULE17]
                                   st_r.int_set[INT_POL0_BIT]); // [RULE10]
            end
            if (st_r.int_set[INT_EN1_BIT]) begin // [RULE9]
                ev[15:8] = edge_evt(st_r.prev[15:8], lvl[1], // [RULE17]
                                    st_r.int_set[INT_POL1_BIT]); // [RULE11]
            end
        end

        // Set wins over clear
        st_nxt.flags = (clr ? FLAGS_RST : st_r.flags) | ev; // [RULE13]
        st_nxt.irq   = |st_nxt.flags; // [RULE20]

        // Address phase
        st_nxt.dph_ok   = aph;
        st_nxt.dph_wr   = hwrite;
        st_nxt.dph_addr = haddr[7:0];
        if (aph && !hwrite) begin
            st_nxt.rdata = (haddr[31:8] == 24'h00_0000) ? // [RULE2]
                           rd_mux(st_nxt, haddr[7:0], lvl) : 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r             <= '0;
            st_r.port_select <= PSEL_RST;
            st_r.deb_lo      <= DEB_RST;
            st_r.deb_hi      <= DEB_RST;
            st_r.int_set     <= INT_SET_RST;
            st_r.flags       <= FLAGS_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic hreadyout_r;
    logic hresp_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b0;
            hresp_r     <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end
    end

    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;
    assign hrdata    = st_r.rdata;
    assign irq       = st_r.irq;
endmodule : dbi_top

// ---- test/dbi_top_properties.sv ----
// Port assertions for the debounced input block
module dbi_top_properties
    import dbi_pkg::*;
#(
    parameter int TICK_PERIOD = TICK_CYCLES,
    parameter int NPORT       = NUM_PORTS
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [1:0]  card_number_jumper,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       rd;
    logic [3:0] since_clr_r;
    assign rd = ce && hsel && htrans[1] && hready && !hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_clr_r <= 4'hf;
        end else if (ce && hsel && htrans[1] && hready && hwrite
                     && haddr[7:0] == OFS_INT_CLEAR) begin
            since_clr_r <= 4'h0;
        end else if (since_clr_r != 4'hf) begin
            since_clr_r <= since_clr_r + 4'h1;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    card_num_a: assert property (
        rd && haddr[7:0] == OFS_CARD_NUM
        |=> hrdata == {30'h0, card_number_jumper} + 32'h1)
        else $error("card number read wrong");
    port_bits_a: assert property (
        rd && haddr[7:0] == OFS_PORT_DATA |=> hrdata[31:8] == 24'h0)
        else $error("port read wider than a byte");
    deb_bits_a: assert property (
        rd && (haddr[7:0] == OFS_DEB_LO || haddr[7:0] == OFS_DEB_HI)
        |=> hrdata[31:7] == 25'h0 && !hrdata[3])
        else $error("unused debounce bits read set");
    set_bits_a: assert property (
        rd && haddr[7:0] == OFS_INT_SET |=> hrdata[31:4] == 28'h0)
        else $error("unused interrupt setting bits read set");
    flag_bits_a: assert property (
        rd && haddr[7:0] == OFS_INT_FLAGS |=> hrdata[31:16] == 16'h0)
        else $error("flags beyond channel 15 read set");
    irq_fall_a: assert property (
        $fell(irq) |-> since_clr_r <= 4'h3)
        else $error("irq dropped without a clear");
    state_freeze_a: assert property (
        !ce |=> $stable(irq) && $stable(hrdata))
        else $error("state moved with clock enable low");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    slave_ready_a: assert property ($past(hresetn) |-> hreadyout)
        else $error("slave not ready");
endmodule : dbi_top_properties

bind dbi_top dbi_top_properties #(
    .TICK_PERIOD(TICK_PERIOD),
    .NPORT      (NPORT)
) i_dbi_top_properties (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .card_number_jumper, .irq
);

// ---- test/dbi_host.sv ----
// Bus master model standing in for host software
module dbi_host (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_late = 0;
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1) n_late++;
    endtask : wait_ready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask : xfer
endmodule : dbi_host

// ---- test/dbi_top_tb.sv ----
// Self-checking bench for the debounced input block
module dbi_top_tb
    import dbi_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TP = 10;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
    } dbi_row_t;
    logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, input_channel;
    logic [1:0]  htrans, card_number_jumper;
    logic [2:0]  hsize;
    logic [7:0]  lv;
    int          fails = 0;
    int          n_checks = 0;
    dbi_row_t    rows [21] = '{
        '{1'b0, OFS_INT_SET, 32'h0}, '{1'b0, OFS_DEB_LO, 32'h0},
        '{1'b0, OFS_INT_FLAGS, 32'h0}, '{1'b0, OFS_PORT_SELECT, 32'h0},
        '{1'b1, OFS_INT_SET, 32'hffffffff}, '{1'b0, OFS_INT_SET, 32'hf},
        '{1'b1, OFS_INT_DISABLE, 32'h0}, '{1'b0, OFS_INT_SET, 32'hc},
        '{1'b1, OFS_DEB_LO, 32'hffffffff}, '{1'b0, OFS_DEB_LO, 32'h77},
        '{1'b1, OFS_DEB_HI, 32'h35}, '{1'b0, OFS_DEB_HI, 32'h35},
        '{1'b1, OFS_DEB_LO, 32'h0}, '{1'b1, OFS_DEB_HI, 32'h0},
        '{1'b1, OFS_PORT_SELECT, 32'hffffffff},
        '{1'b0, OFS_PORT_SELECT, 32'h3},
        '{1'b1, OFS_PORT_DATA, 32'hff}, '{1'b0, OFS_PORT_DATA, 32'h0},
        '{1'b1, OFS_INT_FLAGS, 32'hffff}, '{1'b0, OFS_INT_FLAGS, 32'h0},
        '{1'b0, 8'h24, 32'h0}};

    dbi_top #(.TICK_PERIOD(TP), .NPORT(NUM_PORTS)) i_dbi_top (
        .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .input_channel, .card_number_jumper, .irq);
    dbi_host i_dbi_host (.hclk, .hready(hreadyout), .hrdata, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata);

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic final_report();
        fails += i_dbi_host.n_late;
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_dbi_host.xfer(1'b1, a, d, q);
        if (i_dbi_host.n_late != 0) final_report();
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        i_dbi_host.xfer(1'b0, a, 32'h0, q);
        if (i_dbi_host.n_late != 0) final_report();
        check(q, exp);
    endtask : rdc
    task automatic do_reset(input logic [1:0] j);
        hresetn <= 1'b0;
        card_number_jumper <= j;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask : do_reset
    task automatic ev(input logic [15:0] v, input logic [15:0] exp);
        input_channel[15:0] <= v;
        repeat (4) @(posedge hclk);
        rdc(OFS_INT_FLAGS, {16'h0, exp});
        check({31'h0, irq}, {31'h0, exp != 16'h0});
    endtask : ev
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        input_channel = 32'h0;
        card_number_jumper = 2'h0;
        for (int j = 0; j < 4; j++) begin
            do_reset(2'(j));
            rdc(OFS_CARD_NUM, 32'(j + 1));
        end
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            else rdc(rows[i].a, rows[i].d);
        end
        input_channel <= 32'h5ac33ca5;
        for (int p = 0; p < 4; p++) begin
            wr(OFS_PORT_SELECT, 32'(p));
            lv = 8'(32'h5ac33ca5 >> (8 * p));
            rdc(OFS_PORT_DATA, {24'h0, lv});
        end
        lv = 8'h5a;
        for (int f = 1; f < 8; f++) begin
            wr(OFS_DEB_HI, 32'(f) << 4);
            lv = ~lv;
            input_channel[31:24] <= lv;
            if (f > 1) begin
                repeat ((f - 1) * TP - 1) @(posedge hclk);
                rdc(OFS_PORT_DATA, {24'h0, ~lv});
            end
            repeat (TP + 4) @(posedge hclk);
            rdc(OFS_PORT_DATA, {24'h0, lv});
        end
        input_channel[31:24] <= ~lv;
        repeat (3) @(posedge hclk);
        input_channel[31:24] <= lv;
        repeat (8 * TP) @(posedge hclk);
        rdc(OFS_PORT_DATA, {24'h0, lv});
        for (int p = 0; p < 2; p++) begin
            wr(OFS_DEB_LO, 32'h2 << (4 * p));
            wr(OFS_PORT_SELECT, 32'(p));
            lv = 8'(32'h5ac33ca5 >> (8 * p));
            input_channel[8 * p +: 8] <= 8'h0f;
            repeat (5) @(posedge hclk);
            rdc(OFS_PORT_DATA, {24'h0, lv});
            repeat (2 * TP + 4) @(posedge hclk);
            rdc(OFS_PORT_DATA, 32'h0f);
        end
        wr(OFS_DEB_LO, 32'h0);
        input_channel[15:0] <= 16'h0;
        wr(OFS_INT_SET, 32'h1);
        wr(OFS_INT_CLEAR, 32'h0);
        ce <= 1'b0;
        input_channel[15:0] <= 16'h0204;
        repeat (6) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        ce <= 1'b1;
        ev(16'h0204, 16'h0004);
        wr(OFS_INT_CLEAR, 32'h0);
        ev(16'h0204, 16'h0000);
        wr(OFS_INT_SET, 32'hb);
        ev(16'h0600, 16'h0000);
        ev(16'h0000, 16'h0600);
        wr(OFS_INT_CLEAR, 32'h0);
        wr(OFS_INT_SET, 32'h7);
        ev(16'h0104, 16'h0100);
        ev(16'h0100, 16'h0104);
        wr(OFS_INT_DISABLE, 32'h0);
        rdc(OFS_INT_SET, 32'h4);
        wr(OFS_INT_CLEAR, 32'h0);
        ev(16'h0300, 16'h0000);
        final_report();
    end
endmodule : dbi_top_tb
